// ---- src/srw_reply.v ----
// Satellite channel reply word formatter with fault push and FIFO
`timescale 1ns/1ps
`include "srw_defs.vh"
module srw_reply #(
  parameter FIFO_W = 12,
  parameter SRC_DEPTH = 16,
  parameter SRC_AW = 4,
  parameter IS_FIRST = 1
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_sel_n,
  input wire i_chan_on,
  input wire i_proc_en,
  input wire i_cfg_report,
  input wire i_proto_b,
  input wire i_flush,
  input wire i_data_valid,
  input wire [11:0] i_data,
  output wire o_data_ready,
  input wire i_flt_hs_ilim,
  input wire i_flt_spi_par,
  input wire i_flt_bittime,
  input wire i_flt_few,
  input wire i_flt_many,
  input wire i_flt_crc,
  input wire i_flt_sat_par,
  input wire i_glb_bad_mosi,
  output reg [15:0] o_reply_word,
  output reg o_data_lost_flag,
  output reg [1:0] o_status
);
  localparam CW = `SRW_ENTRY_W;
  localparam DEPTH = `SRW_FIFO_DEPTH;

  // Odd parity over the fifteen other bits
  function par_bit;
    input [14:0] w;
    begin
      par_bit = ~(^w);
    end
  endfunction

  // Restrict a fault code to the legal fault range
  function [CW-1:0] flt_code;
    input [CW-1:0] c;
    begin
      flt_code = (c > `SRW_FAULT_MAX) ? `SRW_FAULT_MAX : c;
    end
  endfunction

  wire sel_s; // Synchronised chip select, low active
  reg sel_q; // Previous synchronised select
  wire sel_fall;
  wire sel_rise;

  srw_sync u_sel_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_sel_n),
    .o_sync(sel_s)
  );

  assign sel_fall = sel_q && !sel_s;
  assign sel_rise = !sel_q && sel_s;

  // Edge memory for the select line
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= 1'b1;
    end else begin
      sel_q <= sel_s;
    end
  end

  // Stage one: incoming sensor data through the 16-word buffer
  wire src_valid;
  wire [11:0] src_data;
  wire src_ready;

  srw_fifo #(
    .WIDTH(12),
    .DEPTH(SRC_DEPTH),
    .AW(SRC_AW)
  ) u_src_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_flush(i_flush),
    .i_in_valid(i_data_valid),
    .o_in_ready(o_data_ready),
    .i_in_data(i_data),
    .o_out_valid(src_valid),
    .i_out_ready(src_ready),
    .o_out_data(src_data)
  );

  // Fault event edge detectors: one pending event per rising occurrence of a fault the protocol uses
  reg [6:0] flt_q; // Previous fault levels
  wire [6:0] flt_now;
  wire [6:0] flt_new;
  reg glb_done_q; // Global fault already latched once

  assign flt_now = {i_flt_sat_par, i_flt_crc, i_flt_many, i_flt_few,
                    i_flt_bittime, i_flt_spi_par, i_flt_hs_ilim};
  assign flt_new = flt_now & ~flt_q;

  // Pending fault events, cleared once picked for a write, even when the full channel FIFO drops them
  reg [6:0] pend_q;
  reg glb_pend_q;
  reg [CW-1:0] wcode; // Word chosen for this cycle's write
  reg wr_en; // A write is attempted this cycle
  reg [6:0] take; // Which pending fault is written
  reg take_glb;
  reg take_src;

  // Pick one write source: global first, then channel faults, then data
  always @* begin
    wcode = `SRW_EMPTY;
    wr_en = 1'b0;
    take = 7'h00;
    take_glb = 1'b0;
    take_src = 1'b0;
    if (glb_pend_q) begin
      wcode = `SRW_G_BAD_MOSI;
      wr_en = 1'b1;
      take_glb = 1'b1;
    end else if (pend_q[0]) begin
      wcode = `SRW_C_HS_ILIM;
      wr_en = 1'b1;
      take[0] = 1'b1;
    end else if (pend_q[1]) begin
      wcode = `SRW_C_SPI_PAR;
      wr_en = 1'b1;
      take[1] = 1'b1;
    end else if (pend_q[2]) begin
      wcode = i_proto_b ? `SRW_CB_FEW : `SRW_CA_BITTIME;
      wr_en = 1'b1;
      take[2] = 1'b1;
    end else if (pend_q[3]) begin
      wcode = i_proto_b ? `SRW_CB_FEW : `SRW_CA_FEW;
      wr_en = 1'b1;
      take[3] = 1'b1;
    end else if (pend_q[4] && i_proto_b) begin
      wcode = `SRW_CB_MANY;
      wr_en = 1'b1;
      take[4] = 1'b1;
    end else if (pend_q[5] && !i_proto_b) begin
      wcode = `SRW_CA_CRC;
      wr_en = 1'b1;
      take[5] = 1'b1;
    end else if (pend_q[6] && i_proto_b) begin
      wcode = `SRW_CB_PAR;
      wr_en = 1'b1;
      take[6] = 1'b1;
    end else if (src_valid) begin
      take_src = 1'b1;
      wr_en = 1'b1;
      if (i_proto_b) begin
        wcode = {1'b1, src_data[10:0]};
      end else if (src_data <= `SRW_FAULT_MAX) begin
        wcode = `SRW_CA_RSVD_MSG;
      end else begin
        wcode = src_data;
      end
    end
    wcode = take_src ? wcode : flt_code(wcode);
  end

  // Data leaves the source buffer only when the channel really takes it;
  // a full channel holds the word back instead of dropping it
  assign src_ready = take_src && push;

  // Protocol-irrelevant pending bits are dropped so they cannot block data
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flt_q <= 7'h00;
      pend_q <= 7'h00;
      glb_pend_q <= 1'b0;
      glb_done_q <= 1'b0;
    end else begin
      flt_q <= flt_now;
      // New events win over the clear of the one being written
      pend_q <= ((pend_q & ~take) | flt_new)
                & (i_proto_b ? 7'h5f : 7'h2f);
      if (IS_FIRST != 0 && i_glb_bad_mosi && !glb_done_q) begin
        glb_pend_q <= 1'b1;
        glb_done_q <= 1'b1;
      end else if (take_glb) begin
        glb_pend_q <= 1'b0;
      end
      if (!i_glb_bad_mosi && !glb_pend_q) begin
        glb_done_q <= 1'b0;
      end
    end
  end

  // Two-location channel FIFO, oldest first
  reg [CW-1:0] ent_q [0:DEPTH-1];
  reg [1:0] cnt_q; // Entries held, 0..2
  reg lost_q; // Data-lost flag
  wire full;
  wire pop;
  wire push;

  assign full = (cnt_q == 2'h2);
  assign pop = sel_rise && (cnt_q != 2'h0);
  assign push = wr_en && (!full || pop);

  // Shift-style storage: slot 0 is always the oldest entry
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ent_q[0] <= `SRW_EMPTY;
      ent_q[1] <= `SRW_EMPTY;
      cnt_q <= 2'h0;
      lost_q <= 1'b0;
    end else if (i_flush) begin
      ent_q[0] <= `SRW_EMPTY;
      ent_q[1] <= `SRW_EMPTY;
      cnt_q <= 2'h0;
    end else begin
      if (pop) begin
        ent_q[0] <= ent_q[1];
        ent_q[1] <= `SRW_EMPTY;
      end
      if (push) begin
        if (pop) begin
          if (cnt_q == 2'h2) begin
            ent_q[1] <= wcode;
          end else begin
            ent_q[0] <= wcode;
          end
        end else if (cnt_q == 2'h0) begin
          ent_q[0] <= wcode;
        end else begin
          ent_q[1] <= wcode;
        end
      end
      cnt_q <= cnt_q + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
      // Lost word sets the flag; a report clears it, a new loss wins
      if (wr_en && !push && !take_src) begin
        lost_q <= 1'b1;
      end else if (sel_rise) begin
        lost_q <= 1'b0;
      end
    end
  end

  // Status field from channel state
  reg [1:0] stat_d;
  always @* begin
    if (i_cfg_report) begin
      stat_d = `SRW_ST_CFG;
    end else if (!i_chan_on) begin
      stat_d = `SRW_ST_OFF;
    end else if (i_proc_en) begin
      stat_d = `SRW_ST_ON_PROC;
    end else begin
      stat_d = `SRW_ST_ON_NOPROC;
    end
  end

  // Reply assembly; entry shown is oldest or zero when empty
  wire [CW-1:0] head;
  wire [14:0] body;
  assign head = (cnt_q == 2'h0) ? `SRW_EMPTY : ent_q[0];
  assign body = {o_status, lost_q, head};

  // Status latched on select fall; word refreshed every cycle from state
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= `SRW_ST_OFF;
      o_reply_word <= 16'h2000;
      o_data_lost_flag <= 1'b0;
    end else begin
      if (sel_fall) begin
        o_status <= stat_d;
      end
      o_reply_word <= {body[14:13], par_bit(body), body[12:0]};
      o_data_lost_flag <= lost_q;
    end
  end
endmodule // srw_reply

// ---- include/srw_defs.vh ----
// Constants for the satellite reply word formatter
`ifndef SRW_DEFS_VH
`define SRW_DEFS_VH
// Reply word field positions
`define SRW_STAT_HI 15
`define SRW_STAT_LO 14
`define SRW_PAR_BIT 13
`define SRW_LOST_BIT 12
`define SRW_ENTRY_W 12
// Status field encodings
`define SRW_ST_OFF 2'h0
`define SRW_ST_ON_NOPROC 2'h1
`define SRW_ST_ON_PROC 2'h2
`define SRW_ST_CFG 2'h3
// Entry values
`define SRW_EMPTY 12'h000
`define SRW_FAULT_MAX 12'h01f
`define SRW_G_BAD_MOSI 12'h002
`define SRW_C_HS_ILIM 12'h010
`define SRW_C_SPI_PAR 12'h012
`define SRW_CA_RSVD_MSG 12'h018
`define SRW_CA_BITTIME 12'h019
`define SRW_CA_FEW 12'h01a
`define SRW_CA_CRC 12'h01c
`define SRW_CB_FEW 12'h019
`define SRW_CB_MANY 12'h01a
`define SRW_CB_PAR 12'h01c
`define SRW_B_DATA_BIT 11
// Channel FIFO depth
`define SRW_FIFO_DEPTH 2
// Source FIFO depth in front of the channels
`define SRW_SRC_DEPTH 16
`endif

// ---- src/srw_sync.v ----
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module srw_sync (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_async,
  output reg o_sync
);
  reg meta_q; // First stage, read only by the second stage

  // Two stages; reset value is idle-high for chip select style inputs
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // srw_sync

// ---- src/srw_fifo.v ----
// Parameterised valid/ready FIFO with honest full and empty
`timescale 1ns/1ps
module srw_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Storage words
  reg [AW-1:0] rd_q; // Read pointer
  reg [AW-1:0] wr_q; // Write pointer
  reg [AW:0] cnt_q; // Fill count
  wire push; // Write accepted
  wire pop; // Read accepted
  reg rdy_q; // Registered room flag, mirrors cnt_q != DEPTH

  // Ready comes from a flop so the port carries no count decode
  assign o_in_ready = rdy_q;
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Advance a pointer with wrap at DEPTH
  function [AW-1:0] nxt;
    input [AW-1:0] p;
    begin
      nxt = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // Pointer and count upkeep; flush empties at once
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= {AW{1'b0}};
      wr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rdy_q <= 1'b1;
    end else if (i_flush) begin
      rd_q <= {AW{1'b0}};
      wr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rdy_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
        rdy_q <= (cnt_q != DEPTH[AW:0] - 1'b1); // Room left after this write
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
        rdy_q <= 1'b1;
      end
    end
  end

  // Storage write; no reset needed for the data words
  always @(posedge i_ref_clk) begin
    if (push && !i_flush) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
endmodule // srw_fifo

// ---- bench/srw_host.sv ----
// Host model that frames each reply word with the chip select
`timescale 1ns/1ps
module srw_host (
  input wire i_clk,
  input wire i_go,
  input wire i_slow,
  input wire [15:0] i_word,
  output reg o_sel_n,
  output reg o_done,
  output reg [15:0] o_word
);
  initial begin
    o_sel_n = 1'b1;
    o_done = 1'b0;
    o_word = 16'h0000;
  end
  // One frame per request; a slow host doubles the select low time
  always @(posedge i_clk) begin
    if (i_go) begin
      @(negedge i_clk);
      o_sel_n = 1'b0;
      repeat (i_slow ? 16 : 8) @(negedge i_clk);
      // Word is taken before the rise, the pop follows it
      o_word = i_word;
      o_sel_n = 1'b1;
      repeat (6) @(negedge i_clk);
      o_done = 1'b1;
      @(negedge i_clk);
      o_done = 1'b0;
    end
  end
endmodule // srw_host

// ---- bench/srw_reply_asserts.sv ----
// Checker on the ports of the reply word formatter
`timescale 1ns/1ps
module srw_reply_chk (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_sel_n,
  input wire i_chan_on,
  input wire i_proc_en,
  input wire i_cfg_report,
  input wire i_flush,
  input wire i_data_valid,
  input wire o_data_ready,
  input wire [15:0] o_reply_word,
  input wire o_data_lost_flag,
  input wire [1:0] o_status
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Status code the controls ask for; config report wins
  wire [1:0] st_e = i_cfg_report ? 2'h3 : !i_chan_on ? 2'h0 : i_proc_en ? 2'h2 : 2'h1;
  property p_par; ^o_reply_word == 1'b1; endproperty
  a_par: assert property (p_par) else $error("reply parity even");
  property p_enc; $fell(i_sel_n) |-> ##[3:5] o_status == st_e; endproperty
  a_enc: assert property (p_enc) else $error("status code wrong");
  property p_stand; $changed(o_status) |-> !$past(i_sel_n, 3) && $past(i_sel_n, 6); endproperty
  a_stand: assert property (p_stand) else $error("status moved off select fall");
  property p_sword; $changed(o_status) |=> o_reply_word[15:14] == o_status; endproperty
  a_sword: assert property (p_sword) else $error("word status stale");
  property p_lword; o_reply_word[12] == o_data_lost_flag; endproperty
  a_lword: assert property (p_lword) else $error("word lost bit stale");
  property p_lclr; $rose(i_sel_n) |-> ##[3:5] !o_data_lost_flag; endproperty
  a_lclr: assert property (p_lclr) else $error("lost flag not cleared");
  property p_lhold; $fell(o_data_lost_flag) |-> $past(i_sel_n, 2); endproperty
  a_lhold: assert property (p_lhold) else $error("lost flag dropped early");
  property p_flush; i_flush && !i_data_valid |-> ##[1:3] o_reply_word[11:0] == 12'h000;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left an entry");
  property p_rdy; i_flush |-> ##[1:2] o_data_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("not ready after flush");
endmodule // srw_reply_chk
bind srw_reply srw_reply_chk u_chk (.i_ref_clk, .i_rst_n, .i_sel_n, .i_chan_on, .i_proc_en,
  .i_cfg_report, .i_flush, .i_data_valid, .o_data_ready, .o_reply_word, .o_data_lost_flag,
  .o_status);

// ---- bench/srw_reply_bench.sv ----
// Self-checking bench for the reply word formatter
`timescale 1ns/1ps
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
  n_fail = n_fail + 1; $display("BAD %0t got %h exp %h", $time, a, b); end end
module srw_reply_bench;
  reg clk = 0, rst_n = 0, on = 0, pen = 0, cfg = 0, pb = 0, fl = 0, vld = 0, gmo = 0;
  reg go = 0, slow = 0;
  reg [11:0] dat = 0;
  reg [6:0] flt = 0; // Fault levels, bit order as the fault code table
  wire rdy, lost, sel_n, done;
  wire [1:0] st;
  wire [15:0] word, cap;
  integer n_fail = 0, check_count = 0, cyc = 0, i, k, n;
  reg [11:0] q[$]; // Accepted data, oldest first
  always #50 clk = ~clk;
  srw_host host (.i_clk(clk), .i_go(go), .i_slow(slow), .i_word(word), .o_sel_n(sel_n),
    .o_done(done), .o_word(cap));
  srw_reply uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sel_n(sel_n), .i_chan_on(on),
    .i_proc_en(pen), .i_cfg_report(cfg), .i_proto_b(pb), .i_flush(fl), .i_data_valid(vld),
    .i_data(dat), .o_data_ready(rdy), .i_flt_hs_ilim(flt[0]), .i_flt_spi_par(flt[1]),
    .i_flt_bittime(flt[2]), .i_flt_few(flt[3]), .i_flt_many(flt[4]), .i_flt_crc(flt[5]),
    .i_flt_sat_par(flt[6]), .i_glb_bad_mosi(gmo), .o_reply_word(word),
    .o_data_lost_flag(lost), .o_status(st));
  // Expected word: parity makes the total count of ones odd
  function [15:0] ew(input [1:0] s, input l, input [11:0] e);
    ew = {s, ~^{s, l, e}, l, e};
  endfunction
  // Code per fault source and protocol; zero where the protocol drops it
  function [11:0] fc(input b, input integer j);
    reg [83:0] t;
    begin
      t = b ? 84'h01c00001a019019012010 : 84'h00001c00001a019012010;
      fc = t[j*12 +: 12];
    end
  endfunction
  // Entry for a sensor word: B marks data in bit 11, A turns low values into a fault
  function [11:0] de(input b, input [11:0] d);
    de = b ? {1'b1, d[10:0]} : (d < 12'h020 ? 12'h018 : d);
  endfunction
  task frame(input [15:0] e);
    begin
      @(negedge clk); go = 1;
      @(posedge clk); @(negedge clk); go = 0;
      @(posedge done);
      `CHK(cap, e)
    end
  endtask
  // Each rising edge of a fault level is one occurrence
  task pulse(input integer j);
    begin
      @(negedge clk); flt[j] = 1;
      @(negedge clk); flt[j] = 0;
      repeat (3) @(negedge clk);
    end
  endtask
  // Request held until ready is seen at a rising edge
  task send(input [11:0] d);
    begin
      @(negedge clk); vld = 1; dat = d;
      while (rdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk); vld = 0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Hang guard, far above the roughly 1100 cycles the run needs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin n_fail = n_fail + 1; summarize; end
  end
  initial begin
    n = $urandom(32'hf5b2);
    repeat (16) @(negedge clk);
    rst_n = 1;
    @(negedge clk); `CHK(word, 16'h2000)
    for (i = 0; i < 4; i = i + 1) begin
      {cfg, on, pen} = (i == 3) ? 3'b110 : {1'b0, i[1] | i[0], i[1]};
      frame(ew(i[1:0], 1'b0, 12'h000));
    end
    $display("end status");
    {cfg, on, pen} = 3'b011;
    for (k = 0; k < 2; k = k + 1) begin
      pb = k[0];
      for (i = 0; i < 7; i = i + 1) begin
        pulse(i);
        frame(ew(2'h2, 1'b0, fc(pb, i)));
      end
    end
    pb = 0;
    $display("end codes");
    pulse(0); pulse(1); pulse(2);
    frame(ew(2'h2, 1'b1, 12'h010));
    frame(ew(2'h2, 1'b0, 12'h012));
    frame(ew(2'h2, 1'b0, 12'h000));
    @(negedge clk); gmo = 1; repeat (4) @(negedge clk);
    frame(ew(2'h2, 1'b0, 12'h002));
    frame(ew(2'h2, 1'b0, 12'h000));
    gmo = 0; repeat (3) @(negedge clk); gmo = 1; repeat (4) @(negedge clk);
    frame(ew(2'h2, 1'b0, 12'h002));
    gmo = 0;
    $display("end overflow and global");
    for (i = 0; i < 8; i = i + 1) begin
      pb = i[0];
      n = $urandom;
      if (i == 2) n = 5;
      if (i == 4) n = 32'h20;
      send(n[11:0]); repeat (4) @(negedge clk);
      frame(ew(2'h2, 1'b0, de(pb, n[11:0])));
    end
    pb = 0;
    @(negedge clk); vld = 1; dat = 12'h020 + $urandom % 12'hfe0;
    // Ready seen at the falling edge decides the take at the next rising edge
    for (i = 0; i < 24; i = i + 1) begin
      if (rdy === 1'b1) begin
        q.push_back(dat);
        @(negedge clk);
        dat = 12'h020 + $urandom % 12'hfe0;
      end else @(negedge clk);
    end
    vld = 0;
    `CHK(q.size(), 18)
    while (q.size() > 0) begin slow = ~slow; frame(ew(2'h2, 1'b0, q.pop_front())); end
    frame(ew(2'h2, 1'b0, 12'h000));
    send(12'h123); send(12'h456); repeat (4) @(negedge clk);
    fl = 1; @(negedge clk); fl = 0; repeat (3) @(negedge clk);
    frame(ew(2'h2, 1'b0, 12'h000));
    $display("end data and flush");
    summarize;
  end
endmodule // srw_reply_bench
